//--- hw/rsf_reset_source.sv
// Reset-source merge, reset cause register and undervoltage detector settings.
//
// Behaviour
// - Watchdog sets its flag; undervoltage sets its own.
// - Pin, power clear, cause read clear register.
// - Cause register byte-wide; bits 4, 0 only.
// - Undervoltage settings cleared except undervoltage reset.
// - Power clear holds reset until upper threshold.
// - Low supply reasserts reset until upper threshold.
// - Reset leaves all other state unchanged.
// - Watchdog enable reset value from option byte.
// - Interrupt flags zero, masks and priorities ones.
// - USB control registers zero; data left undefined.
// - Enabled reset-mode detector resets on low supply.
`timescale 1ns/1ps
`default_nettype none

module rsf_reset_source (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reset_pin_n,
  input  wire logic        supply_above_upper,
  input  wire logic        supply_below_lower,
  input  wire logic        supply_below_uv_level,
  input  wire logic        watchdog_reset_req,
  input  wire logic        power_clear_mode_select,
  input  wire logic        watchdog_enable_option,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  output logic             internal_reset_n,
  output logic             uv_interrupt,
  output logic             uv_level_select,
  output logic      [7:0]  watchdog_enable_reset_value,
  output logic      [7:0]  intr_flag_reset_value,
  output logic      [7:0]  intr_mask_reset_value,
  output logic      [7:0]  intr_priority_reset_value,
  output logic      [7:0]  intr_edge_reset_value,
  output logic      [7:0]  usb_ctrl_reset_value,
  output logic             usb_bulk_out_data_load,
  output logic             power_clear_mode_error
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus decode.

  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    hit = (a == target);
  endfunction

  logic rd_cause;
  logic wr_uvc;
  logic wr_uvl;

  assign rd_cause = bus_rd && hit(bus_addr, rsf_pkg::ADDR_RESET_CAUSE);
  assign wr_uvc   = bus_wr && hit(bus_addr, rsf_pkg::ADDR_UV_CONTROL);
  assign wr_uvl   = bus_wr && hit(bus_addr, rsf_pkg::ADDR_UV_LEVEL);

  ////////////////////////////////////////////////////////////////////////////////
  // Power-on-clear sequencer.

  rsf_pkg::rsf_poc_e poc_q;
  rsf_pkg::rsf_poc_e poc_d;

  always_comb begin
    poc_d = poc_q;
    case (poc_q)
      rsf_pkg::POC_HOLD: begin
        if (supply_above_upper) begin
          poc_d = rsf_pkg::POC_RUN;
        end
      end
      rsf_pkg::POC_RUN: begin
        if (supply_below_lower) begin
          poc_d = rsf_pkg::POC_HOLD;
        end
      end
      default: begin
        poc_d = rsf_pkg::POC_HOLD;
      end
    endcase
  end

  // Power application is modelled by rst_n, so the sequencer starts in hold.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      poc_q <= rsf_pkg::POC_HOLD;
    end else begin
      poc_q <= poc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset requests.

  logic uv_enable_q;
  logic uv_mode_q;
  logic uv_sel_q;
  logic pin_req;
  logic poc_req;
  logic uv_req;
  logic any_req;

  assign pin_req = !reset_pin_n;
  assign poc_req = (poc_q == rsf_pkg::POC_HOLD);
  assign uv_req  = uv_enable_q && uv_mode_q && supply_below_uv_level;
  assign any_req = pin_req || poc_req || watchdog_reset_req || uv_req;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset cause flags and undervoltage settings.

  logic       cause_wdt_q;
  logic       cause_wdt_d;
  logic       cause_uv_q;
  logic       cause_uv_d;
  logic       uv_enable_d;
  logic       uv_mode_d;
  logic       uv_sel_d;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [7:0] cause_byte;
  logic       uv_flag;

  assign uv_flag = uv_enable_q && supply_below_uv_level;

  always_comb begin
    cause_byte = rsf_pkg::BYTE_ZERO;
    cause_byte[rsf_pkg::CAUSE_WDT_BIT] = cause_wdt_q;
    cause_byte[rsf_pkg::CAUSE_UV_BIT]  = cause_uv_q;
  end

  // The flags are never touched by the internal reset they record, only by their own
  // sources, a cause read and pin or power-clear requests, so a watchdog reset does not wipe the undervoltage flag.
  always_comb begin
    cause_wdt_d = cause_wdt_q;
    cause_uv_d  = cause_uv_q;
    if (rd_cause) begin
      cause_wdt_d = 1'b0;
      cause_uv_d  = 1'b0;
    end
    if (watchdog_reset_req) begin
      cause_wdt_d = 1'b1;
    end
    if (uv_req) begin
      cause_uv_d = 1'b1;
    end
    // Pin and power-clear resets win over a coincident set: the record would
    // otherwise survive a full power cycle.
    if (pin_req || poc_req) begin
      cause_wdt_d = 1'b0;
      cause_uv_d  = 1'b0;
    end
  end

  always_comb begin
    uv_enable_d = uv_enable_q;
    uv_mode_d   = uv_mode_q;
    uv_sel_d    = uv_sel_q;
    if (wr_uvc) begin
      uv_enable_d = bus_wdata[rsf_pkg::UVC_ENABLE_BIT];
      uv_mode_d   = bus_wdata[rsf_pkg::UVC_MODE_BIT];
    end
    if (wr_uvl) begin
      uv_sel_d = bus_wdata[rsf_pkg::UVL_SEL_BIT];
    end
    if (pin_req || poc_req || watchdog_reset_req) begin
      uv_enable_d = rsf_pkg::UVC_RESET[rsf_pkg::UVC_ENABLE_BIT];
      uv_mode_d   = rsf_pkg::UVC_RESET[rsf_pkg::UVC_MODE_BIT];
      uv_sel_d    = rsf_pkg::UVL_RESET[rsf_pkg::UVL_SEL_BIT];
    end
  end

  // Reads return a whole byte; a bit-wise read would still clear all flags.
  always_comb begin
    rdata_d = rdata_q;
    if (bus_rd) begin
      rdata_d = rsf_pkg::BYTE_ZERO;
      if (hit(bus_addr, rsf_pkg::ADDR_RESET_CAUSE)) begin
        rdata_d = cause_byte;
      end else if (hit(bus_addr, rsf_pkg::ADDR_UV_CONTROL)) begin
        rdata_d[rsf_pkg::UVC_ENABLE_BIT] = uv_enable_q;
        rdata_d[rsf_pkg::UVC_MODE_BIT]   = uv_mode_q;
        rdata_d[rsf_pkg::UVC_FLAG_BIT]   = uv_flag;
      end else if (hit(bus_addr, rsf_pkg::ADDR_UV_LEVEL)) begin
        rdata_d[rsf_pkg::UVL_SEL_BIT] = uv_sel_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cause_wdt_q <= rsf_pkg::CAUSE_RESET[rsf_pkg::CAUSE_WDT_BIT];
      cause_uv_q  <= rsf_pkg::CAUSE_RESET[rsf_pkg::CAUSE_UV_BIT];
      uv_enable_q <= rsf_pkg::UVC_RESET[rsf_pkg::UVC_ENABLE_BIT];
      uv_mode_q   <= rsf_pkg::UVC_RESET[rsf_pkg::UVC_MODE_BIT];
      uv_sel_q    <= rsf_pkg::UVL_RESET[rsf_pkg::UVL_SEL_BIT];
      rdata_q     <= rsf_pkg::BYTE_ZERO;
    end else begin
      cause_wdt_q <= cause_wdt_d;
      cause_uv_q  <= cause_uv_d;
      uv_enable_q <= uv_enable_d;
      uv_mode_q   <= uv_mode_d;
      uv_sel_q    <= uv_sel_d;
      rdata_q     <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Internal reset and reset defaults for the rest of the chip.

  logic       int_reset_q;
  logic       int_reset_d;
  logic       uv_irq_q;
  logic       uv_irq_d;
  logic       mode_err_q;
  logic       mode_err_d;
  logic [7:0] watchdog_enable_register_q;
  logic [7:0] watchdog_enable_register_d;
  logic [7:0] flag_init_q;
  logic [7:0] flag_init_d;
  logic [7:0] mask_init_q;
  logic [7:0] mask_init_d;
  logic [7:0] usb_init_q;
  logic [7:0] usb_init_d;

  // Default values are presented only while the internal reset is active;
  // outside it they hold, so no other state is disturbed.
  always_comb begin
    int_reset_d = any_req;
    uv_irq_d    = uv_enable_q && !uv_mode_q && supply_below_uv_level;
    mode_err_d  = (power_clear_mode_select != rsf_pkg::POC_MODE_DUAL);
    watchdog_enable_register_d      = watchdog_enable_register_q;
    flag_init_d = flag_init_q;
    mask_init_d = mask_init_q;
    usb_init_d  = usb_init_q;
    if (any_req) begin
      watchdog_enable_register_d      = watchdog_enable_option ? rsf_pkg::WATCHDOG_ENABLE_REGISTER_RESET_HI
                                           : rsf_pkg::WATCHDOG_ENABLE_REGISTER_RESET_LO;
      flag_init_d = rsf_pkg::BYTE_ZERO;
      mask_init_d = rsf_pkg::BYTE_ONES;
      usb_init_d  = rsf_pkg::BYTE_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_reset_q <= 1'b1;
      uv_irq_q    <= 1'b0;
      mode_err_q  <= 1'b0;
      watchdog_enable_register_q      <= rsf_pkg::WATCHDOG_ENABLE_REGISTER_RESET_LO;
      flag_init_q <= rsf_pkg::BYTE_ZERO;
      mask_init_q <= rsf_pkg::BYTE_ONES;
      usb_init_q  <= rsf_pkg::BYTE_ZERO;
    end else begin
      int_reset_q <= int_reset_d;
      uv_irq_q    <= uv_irq_d;
      mode_err_q  <= mode_err_d;
      watchdog_enable_register_q      <= watchdog_enable_register_d;
      flag_init_q <= flag_init_d;
      mask_init_q <= mask_init_d;
      usb_init_q  <= usb_init_d;
    end
  end

  assign bus_rdata                   = rdata_q;
  assign internal_reset_n            = !int_reset_q;
  assign uv_interrupt                = uv_irq_q;
  assign uv_level_select             = uv_sel_q;
  assign watchdog_enable_reset_value = watchdog_enable_register_q;
  assign intr_flag_reset_value       = flag_init_q;
  assign intr_edge_reset_value       = flag_init_q;
  assign intr_mask_reset_value       = mask_init_q;
  assign intr_priority_reset_value   = mask_init_q;
  assign usb_ctrl_reset_value        = usb_init_q;
  assign usb_bulk_out_data_load      = 1'b0;
  assign power_clear_mode_error      = mode_err_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_wdt_alone;
    watchdog_reset_req && reset_pin_n && !poc_req;
  endsequence
  sequence s_uv_alone;
    uv_req && reset_pin_n && !poc_req;
  endsequence
  a_wdt_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
    s_wdt_alone |=> cause_wdt_q && (cause_uv_q == $past(cause_uv_q) || $past(uv_req)))
    else $error("watchdog reset did not set its flag");
  a_uv_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
    s_uv_alone |=> cause_uv_q && (cause_wdt_q == $past(cause_wdt_q)
                                  || $past(watchdog_reset_req)))
    else $error("undervoltage reset did not set its flag");
  a_pin_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_req || poc_req) |=> !cause_wdt_q && !cause_uv_q)
    else $error("pin or power clear did not clear cause");
  a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
    rd_cause && !watchdog_reset_req && !uv_req |=> !cause_wdt_q && !cause_uv_q)
    else $error("cause read did not clear flags");
  a_read_value: assert property (@(posedge clk) disable iff (!rst_n)
    rd_cause |=> bus_rdata == {3'b000, $past(cause_wdt_q), 3'b000, $past(cause_uv_q)})
    else $error("cause read returned wrong byte");
  a_uv_cleared: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_req || poc_req || watchdog_reset_req) |=> !uv_enable_q && !uv_mode_q && !uv_sel_q)
    else $error("undervoltage settings not cleared");
  a_uv_held: assert property (@(posedge clk) disable iff (!rst_n)
    uv_req && reset_pin_n && !poc_req && !watchdog_reset_req && !bus_wr
    |=> $stable(uv_enable_q) && $stable(uv_mode_q) && $stable(uv_sel_q))
    else $error("undervoltage reset changed its settings");
  a_poc_release: assert property (@(posedge clk) disable iff (!rst_n)
    poc_req && !supply_above_upper |=> poc_req)
    else $error("power clear released below upper level");
  a_poc_assert: assert property (@(posedge clk) disable iff (!rst_n)
    !poc_req && supply_below_lower |=> poc_req ##1 !internal_reset_n)
    else $error("power clear did not reassert reset");
  a_reset_merge: assert property (@(posedge clk) disable iff (!rst_n)
    any_req |=> !internal_reset_n)
    else $error("reset request not merged");
  a_watchdog_enable_register_value: assert property (@(posedge clk) disable iff (!rst_n)
    any_req |=> watchdog_enable_reset_value == ($past(watchdog_enable_option)
                ? rsf_pkg::WATCHDOG_ENABLE_REGISTER_RESET_HI : rsf_pkg::WATCHDOG_ENABLE_REGISTER_RESET_LO))
    else $error("watchdog enable reset value wrong");
  a_defaults_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !any_req |=> $stable(intr_mask_reset_value) && $stable(watchdog_enable_reset_value))
    else $error("defaults changed outside reset");
  a_intr_defaults: assert property (@(posedge clk) disable iff (!rst_n)
    any_req |=> intr_flag_reset_value == rsf_pkg::BYTE_ZERO
                && intr_mask_reset_value == rsf_pkg::BYTE_ONES)
    else $error("interrupt defaults wrong");
  a_usb_defaults: assert property (@(posedge clk) disable iff (!rst_n)
    any_req |=> usb_ctrl_reset_value == rsf_pkg::BYTE_ZERO && !usb_bulk_out_data_load)
    else $error("usb defaults wrong");
endmodule

`default_nettype wire

//--- hw/rsf_pkg.sv
// Package with the addresses, field positions and reset values of the reset-source block.
package rsf_pkg;

  // Register addresses on the internal byte bus.
  localparam logic [15:0] ADDR_RESET_CAUSE = 16'hffac;
  localparam logic [15:0] ADDR_UV_CONTROL  = 16'hffbe;
  localparam logic [15:0] ADDR_UV_LEVEL    = 16'hffbf;

  // Field positions of the reset cause register.
  localparam int unsigned CAUSE_WDT_BIT = 4;
  localparam int unsigned CAUSE_UV_BIT  = 0;

  // Field positions of the undervoltage detect control register.
  localparam int unsigned UVC_ENABLE_BIT = 7;
  localparam int unsigned UVC_MODE_BIT   = 1;
  localparam int unsigned UVC_FLAG_BIT   = 0;

  // Field position of the undervoltage level select register.
  localparam int unsigned UVL_SEL_BIT = 0;

  // Reset values.
  localparam logic [7:0] CAUSE_RESET    = 8'h00;
  localparam logic [7:0] UVC_RESET      = 8'h00;
  localparam logic [7:0] UVL_RESET      = 8'h00;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic [7:0] BYTE_ONES      = 8'hff;
  localparam logic [7:0] WATCHDOG_ENABLE_REGISTER_RESET_LO  = 8'h1a;
  localparam logic [7:0] WATCHDOG_ENABLE_REGISTER_RESET_HI  = 8'h9a;

  // Value of the power clear mode select bit that this part must use.
  localparam logic POC_MODE_DUAL = 1'b1;

  // Power-on-clear sequencer states.
  typedef enum logic [1:0] {
    POC_HOLD = 2'b01,
    POC_RUN  = 2'b10
  } rsf_poc_e;

endpackage

//--- testbench/rsf_cpu_model.sv
// Bus master model of the CPU core that reads and writes the reset-source block.
`timescale 1ns/1ps
`default_nettype none

module rsf_cpu_model (
  input  wire logic        clk,
  input  wire logic [7:0]  bus_rdata,
  output var  logic [15:0] bus_addr,
  output var  logic        bus_rd,
  output var  logic        bus_wr,
  output var  logic [7:0]  bus_wdata
);
  initial begin
    bus_addr  = 16'h0000;
    bus_rd    = 1'b0;
    bus_wr    = 1'b0;
    bus_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Released address and data lines carry the inverse of the last value, so stale data never passes for fresh.
  task automatic release_bus();
    bus_rd    = 1'b0;
    bus_wr    = 1'b0;
    bus_addr  = ~bus_addr;
    bus_wdata = ~bus_wdata;
  endtask

  // Only whole-byte reads exist here; a bit read would clear flags it never returns.
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    bus_addr = a;
    bus_rd   = 1'b1;
    @(negedge clk);
    release_bus();
    d = bus_rdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_addr  = a;
    bus_wdata = d;
    bus_wr    = 1'b1;
    @(negedge clk);
    release_bus();
  endtask
endmodule

`default_nettype wire

//--- testbench/tb.sv
// Self-checking testbench of the reset-source block.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reset_pin_n = 1'b1;
  logic        supply_above_upper = 1'b0;
  logic        supply_below_lower = 1'b0;
  logic        supply_below_uv_level = 1'b0;
  logic        watchdog_reset_req = 1'b0;
  logic        power_clear_mode_select = 1'b1;
  logic        watchdog_enable_option = 1'b0;
  logic [15:0] bus_addr;
  logic        bus_rd;
  logic        bus_wr;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_rdata;
  logic        internal_reset_n;
  logic        uv_interrupt;
  logic        uv_level_select;
  logic [7:0]  watchdog_enable_register_val;
  logic [7:0]  flag_val;
  logic [7:0]  mask_val;
  logic [7:0]  prio_val;
  logic [7:0]  edge_val;
  logic [7:0]  usb_val;
  logic        bulk_load;
  logic        mode_err;
  int          num_errors = 0;
  int          n_tests = 0;

  always #12.5 clk = ~clk;

  rsf_reset_source rsf_reset_source_i (
    .clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .supply_above_upper(supply_above_upper), .supply_below_lower(supply_below_lower),
    .supply_below_uv_level(supply_below_uv_level), .watchdog_reset_req(watchdog_reset_req),
    .power_clear_mode_select(power_clear_mode_select),
    .watchdog_enable_option(watchdog_enable_option), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .internal_reset_n(internal_reset_n), .uv_interrupt(uv_interrupt),
    .uv_level_select(uv_level_select), .watchdog_enable_reset_value(watchdog_enable_register_val),
    .intr_flag_reset_value(flag_val), .intr_mask_reset_value(mask_val),
    .intr_priority_reset_value(prio_val), .intr_edge_reset_value(edge_val),
    .usb_ctrl_reset_value(usb_val), .usb_bulk_out_data_load(bulk_load),
    .power_clear_mode_error(mode_err)
  );

  rsf_cpu_model rsf_cpu_model_i (
    .clk(clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    rsf_cpu_model_i.rd(a, d);
    chk(nm, e, d);
  endtask

  // Bounded wait, so a reset that never lets go is reported instead of hanging.
  task automatic wait_rel();
    for (int i = 0; i < 8 && internal_reset_n !== 1'b1; i++)
      @(negedge clk);
    chk("internal_reset_n", 8'h01, {7'h00, internal_reset_n});
  endtask

  // Holds one source for two cycles and checks the merged reset and a loaded default.
  task automatic src(input int k);
    @(negedge clk);
    case (k)
      0: watchdog_reset_req = 1'b1;
      1: supply_below_uv_level = 1'b1;
      default: reset_pin_n = 1'b0;
    endcase
    repeat (2) @(negedge clk);
    chk("internal_reset_n", 8'h00, {7'h00, internal_reset_n});
    chk("watchdog_enable_register", watchdog_enable_option ? 8'h9a : 8'h1a, watchdog_enable_register_val);
    watchdog_reset_req = 1'b0;
    supply_below_uv_level = 1'b0;
    reset_pin_n = 1'b1;
    wait_rel();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    repeat (5) @(negedge clk);
    chk("internal_reset_n", 8'h00, {7'h00, internal_reset_n});
    chk("watchdog_enable_register", 8'h1a, watchdog_enable_register_val);
    chk("intr_flag", 8'h00, flag_val);
    chk("intr_edge", 8'h00, edge_val);
    chk("intr_mask", 8'hff, mask_val);
    chk("intr_prio", 8'hff, prio_val);
    chk("usb_ctrl", 8'h00, usb_val);
    chk("bulk_load", 8'h00, {7'h00, bulk_load});
    chk("mode_err", 8'h00, {7'h00, mode_err});
    supply_above_upper = 1'b1;
    wait_rel();
    rsf_cpu_model_i.wr(rsf_pkg::ADDR_RESET_CAUSE, 8'hff);
    rd_chk("cause", rsf_pkg::ADDR_RESET_CAUSE, 8'h00);
    rd_chk("unmapped", 16'hffad, 8'h00);
  endtask

  task automatic t_wdt();
    rsf_cpu_model_i.wr(rsf_pkg::ADDR_UV_CONTROL, 8'h82);
    rsf_cpu_model_i.wr(rsf_pkg::ADDR_UV_LEVEL, 8'h01);
    chk("uv_level_select", 8'h01, {7'h00, uv_level_select});
    watchdog_enable_option = 1'b1;
    src(0);
    rd_chk("cause", rsf_pkg::ADDR_RESET_CAUSE, 8'h10);
    rd_chk("uv_control", rsf_pkg::ADDR_UV_CONTROL, 8'h00);
    rd_chk("uv_level", rsf_pkg::ADDR_UV_LEVEL, 8'h00);
    rd_chk("cause", rsf_pkg::ADDR_RESET_CAUSE, 8'h00);
    watchdog_enable_option = 1'b0;
  endtask

  task automatic t_uv();
    rsf_cpu_model_i.wr(rsf_pkg::ADDR_UV_CONTROL, 8'h82);
    rsf_cpu_model_i.wr(rsf_pkg::ADDR_UV_LEVEL, 8'h01);
    src(1);
    rd_chk("uv_control", rsf_pkg::ADDR_UV_CONTROL, 8'h82);
    rd_chk("uv_level", rsf_pkg::ADDR_UV_LEVEL, 8'h01);
    src(0);
    rd_chk("cause", rsf_pkg::ADDR_RESET_CAUSE, 8'h11);
    rd_chk("uv_control", rsf_pkg::ADDR_UV_CONTROL, 8'h00);
    // Interrupt mode must raise the interrupt and leave the reset alone.
    rsf_cpu_model_i.wr(rsf_pkg::ADDR_UV_CONTROL, 8'h80);
    supply_below_uv_level = 1'b1;
    repeat (3) @(negedge clk);
    chk("uv_interrupt", 8'h01, {7'h00, uv_interrupt});
    chk("internal_reset_n", 8'h01, {7'h00, internal_reset_n});
    rd_chk("uv_control", rsf_pkg::ADDR_UV_CONTROL, 8'h81);
    supply_below_uv_level = 1'b0;
    rsf_cpu_model_i.wr(rsf_pkg::ADDR_UV_CONTROL, 8'h00);
  endtask

  task automatic t_pin();
    rsf_cpu_model_i.wr(rsf_pkg::ADDR_UV_CONTROL, 8'h82);
    src(1);
    src(2);
    rd_chk("cause", rsf_pkg::ADDR_RESET_CAUSE, 8'h00);
    rd_chk("uv_control", rsf_pkg::ADDR_UV_CONTROL, 8'h00);
  endtask

  task automatic t_poc();
    rsf_cpu_model_i.wr(rsf_pkg::ADDR_UV_CONTROL, 8'h82);
    src(1);
    @(negedge clk);
    supply_above_upper = 1'b0;
    supply_below_lower = 1'b1;
    repeat (3) @(negedge clk);
    chk("internal_reset_n", 8'h00, {7'h00, internal_reset_n});
    supply_below_lower = 1'b0;
    repeat (4) @(negedge clk);
    chk("internal_reset_n", 8'h00, {7'h00, internal_reset_n});
    supply_above_upper = 1'b1;
    wait_rel();
    rd_chk("cause", rsf_pkg::ADDR_RESET_CAUSE, 8'h00);
    rd_chk("uv_control", rsf_pkg::ADDR_UV_CONTROL, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_power();
    t_wdt();
    t_uv();
    t_pin();
    t_poc();
    results();
  end

  // The whole sequence needs about 110 cycles; over twenty-five times that means a hang.
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule

`default_nettype wire
